// >>> design/flash_protect_signature.sv
`timescale 1ns/10ps
`default_nettype none
module flash_protect_signature (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [flash_prot_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // flash array read port
  output logic o_fl_rd_req,
  output logic [flash_prot_pkg::FA_W-1:0] o_fl_addr,
  output logic o_fl_info,
  input wire logic i_fl_rd_valid,
  input wire logic [71:0] i_fl_rd_data,
  // other flash accesses, checked here
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic i_acc_fetch,
  input wire logic [flash_prot_pkg::FA_W-1:0] i_acc_addr,
  output logic o_acc_stall,
  output logic o_acc_wr_blocked,
  output logic o_acc_bus_err,
  // flash sequencer events
  input wire logic i_cmd_start,
  input wire logic i_erase_done,
  input wire logic i_erase_mass,
  input wire logic [flash_prot_pkg::FA_W-1:0] i_erase_addr,
  output logic o_key_valid,
  output logic o_sign_done,
  // debug access port
  input wire logic i_dbg_wr,
  input wire logic [31:0] i_dbg_rd_data,
  output logic o_dbg_wr_allow,
  output logic [31:0] o_dbg_rd_data
);
  import flash_prot_pkg::*;

  seq_state_t state;
  seq_state_t next_state;
  logic key_valid;
  logic [31:0] user_setup_reg;
  logic [31:0] write_protect_block0;
  logic [31:0] write_protect_block1;
  logic [1:0] wp_blank;
  logic [1:0] wp_locked;
  logic [FA_W-1:0] sign_start_addr;
  logic [FA_W-1:0] sign_end_addr;
  logic [FA_W-1:0] cur_addr;
  logic [FA_W-1:0] last_addr;
  logic [CRC_W-1:0] crc;
  logic [CRC_W-1:0] signature;
  logic [CRC_W-1:0] stored_sig;
  logic kernel_run;
  logic run_corr;
  logic run_uncorr;
  logic busy;
  logic done_flag;
  logic sign_fail;
  logic ecc_corr;
  logic ecc_uncorr;
  logic [1:0] cmd_fail;
  logic kernel_fail;
  logic [31:0] dbg_rd_q;
  logic [31:0] prdata_q;

  // extended hamming check on a 72-bit read: data 63:0, check 70:64, parity 71
  function automatic logic [65:0] ecc_fix(input logic [71:0] cw);
    logic [6:0] syn;
    logic par;
    logic [63:0] d;
    int k;
    syn = cw[70:64];
    par = ^cw;
    d = cw[63:0];
    k = 0;
    for (int p = 1; p < 72; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (cw[k])
          syn = syn ^ p[6:0];
        k = k + 1;
      end
    end
    k = 0;
    for (int p = 1; p < 72; p++)
    begin
      if ((p & (p - 1)) != 0)
      begin
        if (par && (syn == p[6:0]))
          d[k] = ~d[k];
        k = k + 1;
      end
    end
    // {uncorrectable, corrected, data}
    ecc_fix = {(syn != 7'h00) && !par, par, d};
  endfunction : ecc_fix

  // apb decode; writes act in the access phase, reads are latched in setup
  wire apb_wr = i_psel && i_penable && i_pwrite;
  wire apb_setup_rd = i_psel && !i_penable && !i_pwrite;
  wire hit_key = (i_paddr == OFF_KEY);
  wire hit_setup = (i_paddr == OFF_SETUP);
  wire hit_status = (i_paddr == OFF_STATUS);
  wire hit_cmd = (i_paddr == OFF_CMD);
  wire hit_start = (i_paddr == OFF_SIGN_START);
  wire hit_end = (i_paddr == OFF_SIGN_END);
  wire hit_sig = (i_paddr == OFF_SIGNATURE);
  wire hit_wp0 = (i_paddr == OFF_WP0);
  wire hit_wp1 = (i_paddr == OFF_WP1);
  wire addr_ok = hit_key | hit_setup | hit_status | hit_cmd | hit_start | hit_end |
                 hit_sig | hit_wp0 | hit_wp1;
  wire wr_key = apb_wr && hit_key;
  wire wr_cmd = apb_wr && hit_cmd;
  wire wr_status = apb_wr && hit_status;
  // a protection register takes a write only with key, blank load and no write since reset or its last releasing erase
  wire wp0_ok = key_valid && wp_blank[0] && !wp_locked[0];
  wire wp1_ok = key_valid && wp_blank[1] && !wp_locked[1];
  wire wr_wp0 = apb_wr && hit_wp0;
  wire wr_wp1 = apb_wr && hit_wp1;
  wire sign_req = wr_cmd && (i_pwdata[3:0] == CMD_SIGN) && (state == st_idle);
  wire sign_go = sign_req && key_valid;
  wire sign_refused = sign_req && !key_valid;

  // ecc and crc over the current read
  wire [65:0] fixed = ecc_fix(i_fl_rd_data);
  wire [63:0] rd_data = fixed[63:0];
  wire rd_corr = fixed[64];
  wire rd_uncorr = fixed[65];
  wire [CRC_W-1:0] crc_lo;
  wire [CRC_W-1:0] crc_hi;
  wire last_word = (cur_addr == last_addr);
  wire rd_take = i_fl_rd_valid && o_fl_rd_req;
  wire sig_match = (crc == stored_sig);

  // lower half first, then upper half of the same word
  crc_step #(.DATA_W(32), .CRC_W(CRC_W)) u_crc_lo (
    .i_crc(crc),
    .i_data(rd_data[31:0]),
    .i_poly(CRC_POLY),
    .o_crc(crc_lo)
  );
  crc_step #(.DATA_W(32), .CRC_W(CRC_W)) u_crc_hi (
    .i_crc(crc_lo),
    .i_data(rd_data[63:32]),
    .i_poly(CRC_POLY),
    .o_crc(crc_hi)
  );

  // protection lookup for the outside access: block bit, then 16 kB region
  wire acc_blk = i_acc_addr[BLOCK_BIT];
  wire [4:0] acc_region = i_acc_addr[REGION_MSB:REGION_LSB];
  wire [31:0] acc_wp = acc_blk ? write_protect_block1 : write_protect_block0;
  wire acc_protected = !acc_wp[acc_region];
  wire acc_is_wp_word = (i_acc_addr[FA_W-1:WP_WORD_LSB] == WP0_ADDR[FA_W-1:WP_WORD_LSB]) ||
                        (i_acc_addr[FA_W-1:WP_WORD_LSB] == WP1_ADDR[FA_W-1:WP_WORD_LSB]);
  wire wp_word_nokey = i_acc_valid && i_acc_write && acc_is_wp_word && !key_valid;
  wire loading = (state == st_load0) || (state == st_load1);
  wire sign_blk = o_fl_info ? 1'b0 : cur_addr[BLOCK_BIT];
  wire signing = (state == st_sign) || (state == st_finish);

  // stall while protection is unknown, or while the block is being signed
  assign o_acc_stall = i_acc_valid && (loading || (signing && (acc_blk == sign_blk)));
  assign o_acc_wr_blocked = i_acc_valid && i_acc_write && acc_protected;
  assign o_acc_bus_err = i_acc_valid && i_acc_fetch && kernel_fail;
  assign o_fl_rd_req = loading || (state == st_sign);
  assign o_fl_addr = cur_addr;
  assign o_key_valid = key_valid;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !addr_ok;
  assign o_prdata = prdata_q;
  assign o_dbg_rd_data = dbg_rd_q;
  assign o_dbg_wr_allow = i_dbg_wr && user_setup_reg[SETUP_DBG_BIT];

  // erase events free a written protection register, not its loaded value
  wire blk0_erase_hit = i_erase_done && !i_erase_addr[BLOCK_BIT];
  wire blk1_erase_hit = i_erase_done && i_erase_addr[BLOCK_BIT];
  wire last_page_erase = i_erase_addr[REGION_MSB:LAST_PAGE_LSB] == LAST_PAGE_IDX;
  wire unlock0 = blk0_erase_hit && (i_erase_mass ||
                 (last_page_erase && write_protect_block0[31]));
  wire unlock1 = blk1_erase_hit && (i_erase_mass ||
                 (last_page_erase && write_protect_block1[31]));

  // read mux
  wire [31:0] status_word = {22'h0, wp_locked, kernel_fail, cmd_fail, ecc_uncorr, ecc_corr,
                             sign_fail, done_flag, busy};
  wire [31:0] rd_mux = hit_key ? 32'h00000000 :
                       hit_setup ? user_setup_reg :
                       hit_status ? status_word :
                       hit_start ? {12'h000, sign_start_addr} :
                       hit_end ? {12'h000, sign_end_addr} :
                       hit_sig ? {8'h00, signature} :
                       hit_wp0 ? write_protect_block0 :
                       hit_wp1 ? write_protect_block1 : 32'h00000000;

  // sequencer next state
  always_comb
  begin
    next_state = state;
    case (state)
      st_load0:
        if (rd_take)
          next_state = st_load1;
      st_load1:
        if (rd_take)
          next_state = st_sign;
      st_idle:
        if (sign_go)
          next_state = st_sign;
      st_sign:
        if (rd_take && last_word)
          next_state = st_finish;
      st_finish:
        next_state = st_idle;
      default:
        next_state = st_idle;
    endcase
  end

  // apb read data and debug read gating
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      prdata_q <= 32'h00000000;
      dbg_rd_q <= 32'h00000000;
    end
    else
    begin
      if (apb_setup_rd)
        prdata_q <= rd_mux;
      dbg_rd_q <= user_setup_reg[SETUP_DBG_BIT] ? i_dbg_rd_data : 32'h00000000;
    end
  end

  // key register; a new correct key wins over a clearing event in the same cycle
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      key_valid <= 1'b0;
    else if (wr_key)
      key_valid <= (i_pwdata == UNLOCK_KEY);
    else if (i_cmd_start || wr_cmd || wr_wp0 || wr_wp1)
      key_valid <= 1'b0;
  end

  // setup and sign address registers
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      user_setup_reg <= SETUP_RESET;
      sign_start_addr <= '0;
      sign_end_addr <= '0;
    end
    else
    begin
      if (apb_wr && hit_setup)
        user_setup_reg <= i_pwdata;
      if (apb_wr && hit_start)
        sign_start_addr <= i_pwdata[FA_W-1:0];
      if (apb_wr && hit_end)
        sign_end_addr <= i_pwdata[FA_W-1:0];
    end
  end

  // protection registers: loaded from flash, then trial-written from apb
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      write_protect_block0 <= WP_BLANK;
      write_protect_block1 <= WP_BLANK;
      wp_blank <= 2'b00;
      wp_locked <= 2'b00;
    end
    else
    begin
      if (state == st_load0 && rd_take)
      begin
        write_protect_block0 <= rd_data[31:0];
        wp_blank[0] <= (rd_data[31:0] == WP_BLANK);
      end
      else if (wr_wp0 && wp0_ok)
        write_protect_block0 <= i_pwdata;
      if (state == st_load1 && rd_take)
      begin
        write_protect_block1 <= rd_data[31:0];
        wp_blank[1] <= (rd_data[31:0] == WP_BLANK);
      end
      else if (wr_wp1 && wp1_ok)
        write_protect_block1 <= i_pwdata;
      // an erase only releases the lock; values stay until reset or the next accepted write
      wp_locked[0] <= (wr_wp0 && wp0_ok) || (wp_locked[0] && !unlock0);
      wp_locked[1] <= (wr_wp1 && wp1_ok) || (wp_locked[1] && !unlock1);
    end
  end

  // sequencer: load both words, sign the kernel, then serve sign commands
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      state <= st_load0;
      cur_addr <= WP0_ADDR;
      last_addr <= WP0_ADDR;
      o_fl_info <= 1'b0;
      kernel_run <= 1'b0;
      crc <= CRC_INIT;
      stored_sig <= '0;
      run_corr <= 1'b0;
      run_uncorr <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == st_load0 && rd_take)
        cur_addr <= WP1_ADDR;
      else if (state == st_load1 && rd_take)
      begin
        cur_addr <= KERNEL_FIRST;
        last_addr <= KERNEL_LAST;
        o_fl_info <= 1'b1;
        kernel_run <= 1'b1;
        crc <= CRC_INIT;
        run_corr <= 1'b0;
        run_uncorr <= 1'b0;
      end
      else if (sign_go)
      begin
        cur_addr <= {sign_start_addr[FA_W-1:PAGE_IGNORE_BITS], PAGE_LOW_FIRST};
        last_addr <= {sign_end_addr[FA_W-1:PAGE_IGNORE_BITS], PAGE_LOW_LAST};
        o_fl_info <= 1'b0;
        kernel_run <= 1'b0;
        crc <= CRC_INIT;
        run_corr <= 1'b0;
        run_uncorr <= 1'b0;
      end
      else if (state == st_sign && rd_take)
      begin
        run_corr <= run_corr | rd_corr;
        run_uncorr <= run_uncorr | rd_uncorr;
        if (last_word)
        begin
          crc <= crc_lo;
          stored_sig <= rd_data[32+CRC_W-1:32];
        end
        else
        begin
          crc <= crc_hi;
          cur_addr <= cur_addr + WORD_STEP;
        end
      end
    end
  end

  // status flags; hardware set wins over a write-one clear in the same cycle
  wire fin = (state == st_finish);
  wire [31:0] clr = wr_status ? i_pwdata : 32'h00000000;
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      busy <= 1'b0;
      done_flag <= 1'b0;
      sign_fail <= 1'b0;
      ecc_corr <= 1'b0;
      ecc_uncorr <= 1'b0;
      cmd_fail <= 2'b00;
      kernel_fail <= 1'b0;
      signature <= '0;
      o_sign_done <= 1'b0;
    end
    else
    begin
      busy <= (busy && !fin) || sign_go || (state == st_load1 && rd_take);
      o_sign_done <= fin;
      done_flag <= fin || (done_flag && !clr[ST_DONE]);
      sign_fail <= (fin && !sig_match) || (sign_fail && !clr[ST_SIGN_FAIL]);
      ecc_corr <= (fin && run_corr) || (ecc_corr && !clr[ST_ECC_CORR]);
      ecc_uncorr <= (fin && run_uncorr) || (ecc_uncorr && !clr[ST_ECC_UNCORR]);
      cmd_fail[0] <= (wp_word_nokey && !acc_blk) || (sign_refused && !sign_start_addr[BLOCK_BIT])
                     || (cmd_fail[0] && !clr[ST_CMD_FAIL0]);
      cmd_fail[1] <= (wp_word_nokey && acc_blk) || (sign_refused && sign_start_addr[BLOCK_BIT])
                     || (cmd_fail[1] && !clr[ST_CMD_FAIL1]);
      // a corrected error with a matching result still passes the kernel check
      if (fin && kernel_run)
        kernel_fail <= run_uncorr || !sig_match;
      if (fin)
        signature <= crc;
    end
  end
endmodule : flash_protect_signature
`default_nettype wire

// >>> shared/flash_prot_pkg.sv
`default_nettype none
package flash_prot_pkg;
  // register offsets on the APB side, byte addresses of aligned words
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFF_KEY = 12'h000;
  localparam logic [APB_AW-1:0] OFF_SETUP = 12'h004;
  localparam logic [APB_AW-1:0] OFF_STATUS = 12'h008;
  localparam logic [APB_AW-1:0] OFF_CMD = 12'h00C;
  localparam logic [APB_AW-1:0] OFF_SIGN_START = 12'h010;
  localparam logic [APB_AW-1:0] OFF_SIGN_END = 12'h014;
  localparam logic [APB_AW-1:0] OFF_SIGNATURE = 12'h018;
  localparam logic [APB_AW-1:0] OFF_WP0 = 12'h01C;
  localparam logic [APB_AW-1:0] OFF_WP1 = 12'h020;

  // key and command codes
  localparam logic [31:0] UNLOCK_KEY = 32'hF123F456;
  localparam logic [3:0] CMD_SIGN = 4'h1;

  // flash geometry, byte addresses
  localparam int FA_W = 20;
  localparam logic [FA_W-1:0] WP0_ADDR = 20'h7FFF0;
  localparam logic [FA_W-1:0] WP1_ADDR = 20'hFFFF0;
  localparam logic [FA_W-1:0] WORD_STEP = 20'h00008;
  localparam int PAGE_IGNORE_BITS = 10;
  localparam logic [PAGE_IGNORE_BITS-1:0] PAGE_LOW_FIRST = 10'h000;
  localparam logic [PAGE_IGNORE_BITS-1:0] PAGE_LOW_LAST = 10'h3F8;
  localparam int BLOCK_BIT = 19;
  localparam int REGION_MSB = 18;
  localparam int REGION_LSB = 14;
  localparam int LAST_PAGE_LSB = 13;
  localparam logic [5:0] LAST_PAGE_IDX = 6'h3F;
  localparam int WP_WORD_LSB = 3;
  localparam logic [31:0] WP_BLANK = 32'hFFFFFFFF;

  // kernel area of the information space, signed after reset
  localparam logic [FA_W-1:0] KERNEL_FIRST = 20'h00000;
  localparam logic [FA_W-1:0] KERNEL_LAST = 20'h01FF8;

  // signature generator
  localparam int CRC_W = 24;
  localparam logic [CRC_W-1:0] CRC_POLY = 24'h800063;
  localparam logic [CRC_W-1:0] CRC_INIT = 24'hFFFFFF;

  // reset values and status layout
  localparam logic [31:0] SETUP_RESET = 32'h00000001;
  localparam int SETUP_DBG_BIT = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_SIGN_FAIL = 2;
  localparam int ST_ECC_CORR = 3;
  localparam int ST_ECC_UNCORR = 4;
  localparam int ST_CMD_FAIL0 = 5;
  localparam int ST_CMD_FAIL1 = 6;
  localparam int ST_KERNEL_FAIL = 7;
  localparam int ST_WP_LOCK0 = 8;
  localparam int ST_WP_LOCK1 = 9;

  typedef enum logic [2:0] {
    st_load0,
    st_load1,
    st_idle,
    st_sign,
    st_finish
  } seq_state_t;
endpackage : flash_prot_pkg
`default_nettype wire

// >>> design/crc_step.sv
`timescale 1ns/10ps
`default_nettype none
// advances a linear feedback CRC over one data word, most significant bit first
module crc_step #(
  parameter int DATA_W = 32,
  parameter int CRC_W = 24
) (
  input wire logic [CRC_W-1:0] i_crc,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic [CRC_W-1:0] i_poly,
  output logic [CRC_W-1:0] o_crc
);
  // serial shift unrolled by the loop; one word per call keeps the fsm simple
  always_comb
  begin
    logic [CRC_W-1:0] c;
    logic fb;
    c = i_crc;
    fb = 1'b0;
    for (int i = DATA_W - 1; i >= 0; i--)
    begin
      fb = c[CRC_W-1] ^ i_data[i];
      c = {c[CRC_W-2:0], 1'b0} ^ (fb ? i_poly : '0);
    end
    o_crc = c;
  end
endmodule : crc_step
`default_nettype wire

// >>> verif/flash_protect_signature_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// port-level relations of the protection and signature logic
module flash_protect_signature_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [flash_prot_pkg::APB_AW-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_fl_rd_req,
  input wire logic [flash_prot_pkg::FA_W-1:0] o_fl_addr,
  input wire logic o_fl_info,
  input wire logic i_fl_rd_valid,
  input wire logic i_acc_valid,
  input wire logic i_acc_write,
  input wire logic i_acc_fetch,
  input wire logic o_acc_wr_blocked,
  input wire logic o_acc_bus_err,
  input wire logic i_cmd_start,
  input wire logic o_key_valid,
  input wire logic o_sign_done,
  input wire logic i_dbg_wr,
  input wire logic [31:0] i_dbg_rd_data,
  input wire logic o_dbg_wr_allow,
  input wire logic [31:0] o_dbg_rd_data
);
  import flash_prot_pkg::*;
  logic key_wr;
  // key write in its access phase; a correct key outranks a same-cycle clear
  assign key_wr = i_psel && i_penable && i_pwrite && i_paddr == OFF_KEY;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  a_load_first: assert property ($fell(i_rst) |-> o_fl_rd_req && o_fl_addr == WP0_ADDR)
    else $error("first protection word not requested");
  a_rd_hold: assert property (o_fl_rd_req && !i_fl_rd_valid |=> o_fl_rd_req && $stable(o_fl_addr))
    else $error("read request dropped or moved");
  a_rd_step: assert property ((o_fl_rd_req && i_fl_rd_valid && o_fl_info) ##1 (o_fl_rd_req && o_fl_info)
    |-> o_fl_addr == $past(o_fl_addr) + WORD_STEP) else $error("read address not ascending");
  a_key_set: assert property (key_wr && i_pwdata == UNLOCK_KEY |=> o_key_valid)
    else $error("unlock key not taken");
  a_key_clear: assert property ((key_wr && i_pwdata != UNLOCK_KEY) || (i_cmd_start && !key_wr)
    |=> !o_key_valid) else $error("key not cleared");
  a_dbg_write: assert property (o_dbg_wr_allow |-> i_dbg_wr)
    else $error("debug write passed without request");
  a_dbg_read: assert property (o_dbg_rd_data != 32'h00000000 |-> o_dbg_rd_data == $past(i_dbg_rd_data))
    else $error("debug read data wrong");
  a_dbg_lock: assert property (i_dbg_wr && !o_dbg_wr_allow |=> o_dbg_rd_data == 32'h00000000)
    else $error("locked debug read not zero");
  a_wr_blocked: assert property (o_acc_wr_blocked |-> i_acc_valid && i_acc_write)
    else $error("block flag without write");
  a_bus_err: assert property (o_acc_bus_err |-> i_acc_valid && i_acc_fetch)
    else $error("bus error without fetch");
  a_done_pulse: assert property (o_sign_done |=> !o_sign_done)
    else $error("done event longer than one cycle");
endmodule : flash_protect_signature_checker
bind flash_protect_signature flash_protect_signature_checker chk (
  .i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_fl_rd_req,
  .o_fl_addr, .o_fl_info, .i_fl_rd_valid, .i_acc_valid, .i_acc_write, .i_acc_fetch,
  .o_acc_wr_blocked, .o_acc_bus_err, .i_cmd_start, .o_key_valid, .o_sign_done, .i_dbg_wr,
  .i_dbg_rd_data, .o_dbg_wr_allow, .o_dbg_rd_data
);
`default_nettype wire

// >>> verif/flash_array_model.sv
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_rd_req,
  input wire logic [19:0] i_rd_addr,
  output logic o_rd_valid,
  output logic [71:0] o_rd_data
);
  logic pace;
  logic next_valid;
  // answers on alternate cycles so prompt and slow turns both occur
  assign next_valid = i_rd_req && !o_rd_valid && pace;
  // zero data with zero check bits is a clean codeword whatever the code layout;
  // outside a valid cycle the data toggles so a stale word never looks good;
  // the second word of block 1 carries a single flipped data bit the code repairs
  always_ff @(posedge i_sys_clk)
  begin
    pace <= i_rst ? 1'b0 : !pace;
    o_rd_valid <= !i_rst && next_valid;
    o_rd_data <= (i_rst || next_valid) ? {71'h0, next_valid && (i_rd_addr == 20'h80008)} :
                 ~o_rd_data;
  end
endmodule : flash_array_model
`default_nettype wire

// >>> verif/flash_protect_signature_bench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) \
  begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module flash_protect_signature_bench;
  import flash_prot_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [APB_AW-1:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h00000000, i_dbg_rd_data = 32'h00000000, rd;
  logic i_acc_valid = 1'b0, i_acc_write = 1'b0, i_acc_fetch = 1'b0, i_cmd_start = 1'b0;
  logic i_dbg_wr = 1'b0, i_erase_done = 1'b0, i_erase_mass = 1'b0;
  logic [FA_W-1:0] i_acc_addr = 20'h00000, i_erase_addr = 20'h00000, o_fl_addr;
  logic [31:0] o_prdata, o_dbg_rd_data;
  logic [71:0] i_fl_rd_data;
  logic o_pready, o_pslverr, o_fl_rd_req, o_fl_info, i_fl_rd_valid, o_acc_stall;
  logic o_acc_wr_blocked, o_acc_bus_err, o_key_valid, o_sign_done, o_dbg_wr_allow;
  int bad_count = 0, samples_checked = 0, cycles = 0;

  flash_protect_signature dut (
    .i_sys_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .o_fl_rd_req, .o_fl_addr, .o_fl_info, .i_fl_rd_valid, .i_fl_rd_data,
    .i_acc_valid, .i_acc_write, .i_acc_fetch, .i_acc_addr, .o_acc_stall, .o_acc_wr_blocked,
    .o_acc_bus_err, .i_cmd_start, .i_erase_done, .i_erase_mass, .i_erase_addr, .o_key_valid,
    .o_sign_done, .i_dbg_wr, .i_dbg_rd_data, .o_dbg_wr_allow, .o_dbg_rd_data
  );
  flash_array_model flash (
    .i_sys_clk, .i_rst, .i_rd_req(o_fl_rd_req), .i_rd_addr(o_fl_addr), .o_rd_valid(i_fl_rd_valid),
    .o_rd_data(i_fl_rd_data)
  );

  task automatic final_report;
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic tick;
    @(posedge i_sys_clk);
    #1;
  endtask : tick

  // one apb transfer, zero wait states; read data lands in rd
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    tick;
    i_psel = 1'b1;
    i_pwrite = w;
    i_paddr = a;
    i_pwdata = d;
    tick;
    i_penable = 1'b1;
    @(posedge i_sys_clk);
    rd = o_prdata;
    #1;
    i_psel = 1'b0;
    i_penable = 1'b0;
  endtask : apb

  // signature of n zero half-words; after ecc correction the model only ever returns zero data
  function automatic logic [23:0] crc_zero(input int n);
    logic [23:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n * 32; i++)
      c = c[23] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction : crc_zero

  task automatic wait_idle;
    rd = 32'h00000001;
    for (int n = 0; n < 4000 && rd[ST_BUSY] !== 1'b0; n++)
      apb(1'b0, OFF_STATUS, 32'h00000000);
    `CHK("busy end", 1'b0, rd[ST_BUSY])
  endtask : wait_idle

  // zero words loaded: every region protected, kernel signature mismatches
  task automatic t_boot;
    i_acc_valid = 1'b1;
    i_acc_write = 1'b1;
    i_acc_addr = 20'h44000;
    #1;
    `CHK("load stall", 1'b1, o_acc_stall)
    for (int n = 0; n < 100 && o_fl_info !== 1'b1; n++)
      tick;
    wait_idle;
    `CHK("blocked", 1'b1, o_acc_wr_blocked)
    i_acc_write = 1'b0;
    i_acc_fetch = 1'b1;
    #1;
    `CHK("fetch error", 1'b1, o_acc_bus_err)
    i_acc_valid = 1'b0;
    i_acc_fetch = 1'b0;
    apb(1'b0, OFF_STATUS, 32'h00000000);
    `CHK("kernel fail", 1'b1, rd[ST_KERNEL_FAIL])
    apb(1'b0, OFF_WP0, 32'h00000000);
    `CHK("wp0 loaded", 32'h00000000, rd)
    apb(1'b0, OFF_SIGNATURE, 32'h00000000);
    `CHK("kernel sig", crc_zero(2047), rd[23:0])
  endtask : t_boot

  task automatic t_key;
    apb(1'b1, OFF_WP0, 32'hFFFFFFFF);
    apb(1'b0, OFF_WP0, 32'h00000000);
    `CHK("wp0 no key", 32'h00000000, rd)
    apb(1'b1, OFF_KEY, UNLOCK_KEY);
    `CHK("key set", 1'b1, o_key_valid)
    apb(1'b1, OFF_WP1, 32'hFFFFFFFF);
    `CHK("key after wp", 1'b0, o_key_valid)
    apb(1'b0, OFF_WP1, 32'h00000000);
    `CHK("wp1 kept", 32'h00000000, rd)
    apb(1'b1, OFF_KEY, UNLOCK_KEY);
    apb(1'b1, OFF_KEY, 32'h00000001);
    `CHK("key wrong", 1'b0, o_key_valid)
    apb(1'b1, OFF_KEY, UNLOCK_KEY);
    i_cmd_start = 1'b1;
    tick;
    i_cmd_start = 1'b0;
    `CHK("key cmd", 1'b0, o_key_valid)
  endtask : t_key

  task automatic t_debug;
    i_dbg_rd_data = 32'hA5C30F96;
    i_dbg_wr = 1'b1;
    tick;
    `CHK("dbg allow", 1'b1, o_dbg_wr_allow)
    `CHK("dbg read", 32'hA5C30F96, o_dbg_rd_data)
    apb(1'b1, OFF_SETUP, 32'h00000000);
    tick;
    `CHK("dbg locked", 1'b0, o_dbg_wr_allow)
    `CHK("dbg zero", 32'h00000000, o_dbg_rd_data)
    apb(1'b1, OFF_SETUP, SETUP_RESET);
    i_dbg_wr = 1'b0;
  endtask : t_debug

  // one page of block 1, unaligned start and end to show page granularity
  task automatic t_sign;
    apb(1'b1, OFF_SIGN_START, 32'h00080123);
    apb(1'b1, OFF_SIGN_END, 32'h000803FF);
    apb(1'b1, OFF_CMD, {28'h0000000, CMD_SIGN});
    apb(1'b0, OFF_STATUS, 32'h00000000);
    `CHK("no key fail", 2'b10, {rd[ST_CMD_FAIL1], rd[ST_BUSY]})
    apb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
    apb(1'b1, OFF_KEY, UNLOCK_KEY);
    apb(1'b1, OFF_CMD, {28'h0000000, CMD_SIGN});
    apb(1'b0, OFF_STATUS, 32'h00000000);
    `CHK("busy", 3'b100, {rd[ST_BUSY], rd[ST_DONE], rd[ST_SIGN_FAIL]})
    i_acc_valid = 1'b1;
    i_acc_addr = 20'h80000;
    #1;
    `CHK("stall same", 1'b1, o_acc_stall)
    i_acc_addr = 20'h00000;
    #1;
    `CHK("stall other", 1'b0, o_acc_stall)
    i_acc_valid = 1'b0;
    wait_idle;
    `CHK("done fail", 2'b11, {rd[ST_DONE], rd[ST_SIGN_FAIL]})
    `CHK("ecc flags", 2'b10, {rd[ST_ECC_CORR], rd[ST_ECC_UNCORR]})
    apb(1'b0, OFF_SIGNATURE, 32'h00000000);
    `CHK("user sig", crc_zero(255), rd[23:0])
  endtask : t_sign

  // free-running clock
  initial
  begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  // a hang counts against the run
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      final_report;
    end
  end

  // reset for two cycles, then the scenarios in turn
  initial
  begin
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    t_boot;
    t_key;
    t_debug;
    t_sign;
    final_report;
  end
endmodule : flash_protect_signature_bench
`default_nettype wire
